/* File: verilog/bpc_pkg.sv */
// Package: register map, field positions and reset values of the port block
package bpc_pkg;
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 12;
    // Byte offsets: port p occupies a 16-byte slot at p * PORT_STRIDE
    localparam logic [ADDR_W-1:0] PORT_STRIDE = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_PINS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h044;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] OUTPUT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // Port index that carries wakeup and timer-two inputs
    localparam int WAKE_PORT = 2;
    localparam int TIMER_A_BIT = 4;
    localparam int TIMER_B_BIT = 5;
    localparam logic [ADDR_W-1:0] SLOT_MASK = 12'hFF0;
    localparam logic [ADDR_W-1:0] REG_MASK = 12'h00F;
endpackage : bpc_pkg

/* File: verilog/bpc_port.sv */
// Three 8-bit bidirectional ports with APB registers and wakeup events
//
// Contract
// - Three 8-bit ports, each bit independently input, output or high-Z.
// - Each port has readable and writable config and output registers.
// - A third location per port returns live input pin levels.
// - Config 0/data 0 high-Z, 0/1 pull-up input, 1 drives data bit.
// - All eight wake-port pins feed the multi-input wakeup logic.
// - Wake-port bits four and five also feed timer two inputs.
// - Reset clears config and output registers; all pins high-Z input.
`timescale 1ns/10ps
module bpc_port (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [23:0] PIN_I,
    output logic [23:0] PIN_O,
    output logic [23:0] PIN_OE_N_O,
    output logic [23:0] PULLUP_EN_O,
    output logic [7:0] MULTI_INPUT_WAKEUP_O,
    output logic TIMER_TWO_INPUT_A_O,
    output logic TIMER_TWO_INPUT_B_O,
    output logic IRQ_O
);
    localparam int W = bpc_pkg::PORT_W;
    localparam int N = bpc_pkg::NUM_PORTS;

    logic [7:0] cfg_ff [N];
    logic [7:0] out_ff [N];
    logic [7:0] oe_n_ff [N];
    logic [7:0] pu_ff [N];
    logic [23:0] sync1_ff;
    logic [23:0] sync2_ff;
    logic [7:0] wake_prev_ff;
    logic [7:0] irq_status_ff;
    logic [7:0] irq_mask_ff;
    logic [7:0] nxt_status;
    logic [7:0] wake_change;
    logic access;
    logic wr;
    logic [1:0] slot;
    logic slot_ok;
    logic [3:0] reg_sel;
    logic mapped;
    logic [31:0] rdata;

    // Port slot index from address; 3 marks a non-port slot
    function automatic logic [1:0] port_slot(input logic [11:0] a);
        logic [11:0] s;
        s = a & bpc_pkg::SLOT_MASK;
        if (s == 12'h000) return 2'h0;
        if (s == bpc_pkg::PORT_STRIDE) return 2'h1;
        if (s == (bpc_pkg::PORT_STRIDE << 1)) return 2'h2;
        return 2'h3;
    endfunction : port_slot

    assign access = PSEL_I && PENABLE_I;
    assign wr = access && PWRITE_I;
    assign slot = port_slot(PADDR_I);
    assign slot_ok = (slot != 2'h3);
    assign reg_sel = PADDR_I[3:0] & bpc_pkg::REG_MASK[3:0];

    // Registers per port; write takes effect at the access edge
    generate
        for (genvar p = 0; p < N; p++) begin : g_port
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    cfg_ff[p] <= bpc_pkg::CONFIG_RST;
                    out_ff[p] <= bpc_pkg::OUTPUT_RST;
                end else if (wr && slot_ok && slot == 2'(p)) begin
                    if (reg_sel == bpc_pkg::OFF_CONFIG[3:0]) begin
                        cfg_ff[p] <= PWDATA_I[W-1:0];
                    end
                    if (reg_sel == bpc_pkg::OFF_OUTPUT[3:0]) begin
                        out_ff[p] <= PWDATA_I[W-1:0];
                    end
                end
            end
            // Pin enables kept in their own flops, loaded by the same
            // write, so that every pin control leaves straight from a flop
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    oe_n_ff[p] <= ~bpc_pkg::CONFIG_RST;
                    pu_ff[p] <= ~bpc_pkg::CONFIG_RST & bpc_pkg::OUTPUT_RST;
                end else if (wr && slot_ok && slot == 2'(p)) begin
                    if (reg_sel == bpc_pkg::OFF_CONFIG[3:0]) begin
                        oe_n_ff[p] <= ~PWDATA_I[W-1:0];
                        pu_ff[p] <= ~PWDATA_I[W-1:0] & out_ff[p];
                    end
                    if (reg_sel == bpc_pkg::OFF_OUTPUT[3:0]) begin
                        pu_ff[p] <= ~cfg_ff[p] & PWDATA_I[W-1:0];
                    end
                end
            end
            // Pin drive mirrors the flops directly, no extra delay
            for (genvar b = 0; b < W; b++) begin : g_bit
                assign PIN_O[p*W+b] = out_ff[p][b];
                assign PIN_OE_N_O[p*W+b] = oe_n_ff[p][b];
                assign PULLUP_EN_O[p*W+b] = pu_ff[p][b];
            end
        end
    endgenerate

    // Two-stage synchroniser on every pin
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sync1_ff <= 24'h000000;
            sync2_ff <= 24'h000000;
        end else begin
            sync1_ff <= PIN_I;
            sync2_ff <= sync1_ff;
        end
    end

    // Wakeup and timer taps from the synchronised wake port
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            MULTI_INPUT_WAKEUP_O <= 8'h00;
            TIMER_TWO_INPUT_A_O <= 1'b0;
            TIMER_TWO_INPUT_B_O <= 1'b0;
            wake_prev_ff <= 8'h00;
        end else begin
            MULTI_INPUT_WAKEUP_O <=
                sync2_ff[bpc_pkg::WAKE_PORT*W +: W];
            TIMER_TWO_INPUT_A_O <=
                sync2_ff[bpc_pkg::WAKE_PORT*W + bpc_pkg::TIMER_A_BIT];
            TIMER_TWO_INPUT_B_O <=
                sync2_ff[bpc_pkg::WAKE_PORT*W + bpc_pkg::TIMER_B_BIT];
            wake_prev_ff <= sync2_ff[bpc_pkg::WAKE_PORT*W +: W];
        end
    end

    // Change on any wake pin is an event; levels held one cycle seen
    assign wake_change =
        sync2_ff[bpc_pkg::WAKE_PORT*W +: W] ^ wake_prev_ff;

    // Sticky status, write-one-to-clear, set wins over clear
    always_comb begin
        nxt_status = irq_status_ff;
        if (wr && PADDR_I == bpc_pkg::OFF_IRQ_STATUS) begin
            nxt_status = irq_status_ff & ~PWDATA_I[7:0];
        end
        nxt_status = nxt_status | wake_change;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_status_ff <= 8'h00;
        end else begin
            irq_status_ff <= nxt_status;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_mask_ff <= bpc_pkg::MASK_RST;
        end else if (wr && PADDR_I == bpc_pkg::OFF_IRQ_MASK) begin
            irq_mask_ff <= PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(nxt_status & irq_mask_ff);
        end
    end

    // Read mux; pin location shows synchronised pin level, even outputs
    always_comb begin
        rdata = 32'h00000000;
        mapped = 1'b1;
        if (slot_ok && reg_sel == bpc_pkg::OFF_CONFIG[3:0]) begin
            rdata[W-1:0] = cfg_ff[slot];
        end else if (slot_ok && reg_sel == bpc_pkg::OFF_OUTPUT[3:0]) begin
            rdata[W-1:0] = out_ff[slot];
        end else if (slot_ok && reg_sel == bpc_pkg::OFF_PINS[3:0]) begin
            if (!PWRITE_I) begin
                rdata[W-1:0] = sync2_ff[slot*W +: W];
            end else begin
                mapped = 1'b0;
            end
        end else if (PADDR_I == bpc_pkg::OFF_IRQ_STATUS) begin
            rdata[7:0] = irq_status_ff;
        end else if (PADDR_I == bpc_pkg::OFF_IRQ_MASK) begin
            rdata[7:0] = irq_mask_ff;
        end else begin
            mapped = 1'b0;
        end
    end

    // No wait state: ready registered in setup, answer in first access cycle
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && !PENABLE_I) begin
            PREADY_O <= 1'b1;
            PRDATA_O <= rdata;
            PSLVERR_O <= ~mapped;
        end else begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

    // Checks on the block's own outputs and state
    a_reset_clears: assert property (
        @(posedge CLK_I) $past(RST_I)
        |-> (PIN_OE_N_O == 24'hFFFFFF && PULLUP_EN_O == 24'h0))
        else $error("pins not high-Z after reset");
    a_reset_drive: assert property (
        @(posedge CLK_I) $past(RST_I)
        |-> (PIN_O == 24'h0 && !IRQ_O && !PREADY_O))
        else $error("outputs not idle after reset");
    a_out_drive: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (wr && slot == 2'h0 && reg_sel == 4'h4)
        |=> PIN_O[7:0] == $past(PWDATA_I[7:0]))
        else $error("output write did not reach pins");
    a_cfg_enable: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (wr && slot == 2'h1 && reg_sel == 4'h0)
        |=> PIN_OE_N_O[15:8] == ~$past(PWDATA_I[7:0]))
        else $error("config write wrong enables");
    a_pullup_mode: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        PULLUP_EN_O == (PIN_OE_N_O & PIN_O))
        else $error("pull-up mode mismatch");
    a_oe_follows: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        PIN_OE_N_O[7:0] == ~cfg_ff[0])
        else $error("enable flop out of step with config");
    a_pu_follows: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        PULLUP_EN_O[23:16] == (~cfg_ff[2] & out_ff[2]))
        else $error("pull-up flop out of step with registers");
    a_pin_read: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (PSEL_I && !PENABLE_I && !PWRITE_I && slot == 2'h2 && reg_sel == 4'h8)
        |=> PREADY_O && PRDATA_O[7:0] == $past(sync2_ff[23:16]))
        else $error("pin read wrong");
    a_pin_write_err: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (PSEL_I && !PENABLE_I && PWRITE_I && slot_ok && reg_sel == 4'h8)
        |=> PREADY_O && PSLVERR_O)
        else $error("pin location write not refused");
    a_unmapped_err: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (PSEL_I && !PENABLE_I && !slot_ok
        && PADDR_I != bpc_pkg::OFF_IRQ_STATUS
        && PADDR_I != bpc_pkg::OFF_IRQ_MASK)
        |=> PREADY_O && PSLVERR_O)
        else $error("unmapped access not refused");
    a_ready_pulse: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");
    a_cfg_readback: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (PSEL_I && !PENABLE_I && !PWRITE_I && slot == 2'h0 && reg_sel == 4'h0)
        |=> PRDATA_O[7:0] == cfg_ff[0])
        else $error("config read wrong");
    a_wake_path: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        ##1 MULTI_INPUT_WAKEUP_O == $past(sync2_ff[23:16]))
        else $error("wakeup path wrong");
    a_timer_taps: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        TIMER_TWO_INPUT_A_O == MULTI_INPUT_WAKEUP_O[4]
        && TIMER_TWO_INPUT_B_O == MULTI_INPUT_WAKEUP_O[5])
        else $error("timer taps wrong");
    a_event_sticky: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        wake_change != 8'h00 |=> (irq_status_ff & $past(wake_change)) != 8'h00)
        else $error("wake event lost");
    a_status_clear: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (wr && PADDR_I == bpc_pkg::OFF_IRQ_STATUS)
        |=> (irq_status_ff & $past(PWDATA_I[7:0])
        & ~$past(wake_change)) == 8'h00)
        else $error("status bit not cleared by one");
    a_mask_write: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        (wr && PADDR_I == bpc_pkg::OFF_IRQ_MASK)
        |=> irq_mask_ff == $past(PWDATA_I[7:0]))
        else $error("mask write lost");
    a_irq_level: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        IRQ_O == |(irq_status_ff & $past(irq_mask_ff)))
        else $error("interrupt level wrong");
    c_wake_irq: cover property (@(posedge CLK_I) disable iff (RST_I)
        IRQ_O);
    c_push_pull: cover property (@(posedge CLK_I) disable iff (RST_I)
        PIN_OE_N_O[0] == 1'b0);
    c_slverr: cover property (@(posedge CLK_I) disable iff (RST_I)
        PREADY_O && PSLVERR_O);
    c_pullup_in: cover property (@(posedge CLK_I) disable iff (RST_I)
        PULLUP_EN_O != 24'h0);
    c_wake_event: cover property (@(posedge CLK_I) disable iff (RST_I)
        wake_change != 8'h00);
endmodule : bpc_port

/* File: verification/bpc_pin_model.sv */
// Partner model: outside circuitry hanging on the 24 port pins
`timescale 1ns/10ps
module bpc_pin_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [23:0] pin_o_i,
    input wire logic [23:0] oe_n_i,
    input wire logic [23:0] pullup_i,
    input wire logic [23:0] ext_val_i,
    input wire logic [23:0] ext_en_i,
    output logic [23:0] level_o
);
    logic [23:0] float_ff;
    // Pins nobody drives wander every cycle
    always_ff @(posedge clk_i) begin
        float_ff <= rst_i ? 24'h000000 : ~float_ff;
    end
    // Device driver first, then outside source, then weak pull-up
    always_comb begin
        level_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_val_i)
            | (oe_n_i & ~ext_en_i & (pullup_i | float_ff));
    end
endmodule : bpc_pin_model

/* File: verification/tb_top.sv */
// Testbench: register, pin setup and wakeup checks of the port block
`timescale 1ns/10ps
module tb_top;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, ta, tb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] lvl, pin_o, oe_n, pu, ext_val, ext_en;
    logic [7:0] wake;
    int bad_count, n_tests;
    bpc_port dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PIN_I(lvl), .PIN_O(pin_o),
        .PIN_OE_N_O(oe_n), .PULLUP_EN_O(pu), .MULTI_INPUT_WAKEUP_O(wake),
        .TIMER_TWO_INPUT_A_O(ta), .TIMER_TWO_INPUT_B_O(tb), .IRQ_O(irq));
    bpc_pin_model ext (.clk_i(clk), .rst_i(rst), .pin_o_i(pin_o),
        .oe_n_i(oe_n), .pullup_i(pu), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .level_o(lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, {24'h000000, x});
    endtask : rd
    function automatic logic [11:0] ad(input int p, input logic [11:0] o);
        return bpc_pkg::PORT_STRIDE * 12'(p) + o;
    endfunction : ad
    task automatic t_reset;
        for (int p = 0; p < 3; p++) begin
            rd(ad(p, bpc_pkg::OFF_CONFIG), bpc_pkg::CONFIG_RST);
            rd(ad(p, bpc_pkg::OFF_OUTPUT), bpc_pkg::OUTPUT_RST);
        end
        chk({8'h00, oe_n}, 32'h00FFFFFF);
        chk({8'h00, pu}, 32'h00000000);
        rd(bpc_pkg::OFF_IRQ_MASK, bpc_pkg::MASK_RST);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int p = 0; p < 3; p++) begin
            wr(ad(p, bpc_pkg::OFF_CONFIG), 8'hA5 ^ 8'(p));
            wr(ad(p, bpc_pkg::OFF_OUTPUT), 8'h5A + 8'(p));
            rd(ad(p, bpc_pkg::OFF_CONFIG), 8'hA5 ^ 8'(p));
            rd(ad(p, bpc_pkg::OFF_OUTPUT), 8'h5A + 8'(p));
            apb(1'b1, ad(p, bpc_pkg::OFF_PINS), 32'h000000FF, r, e);
            chk({31'h0, e}, 32'h1);
        end
        apb(1'b0, 12'h0FC, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
    endtask : t_regs
    task automatic t_setup;
        for (int p = 0; p < 3; p++) begin
            ext_en[8*p +: 8] <= 8'hC0;
            ext_val[8*p +: 8] <= 8'h80;
            wr(ad(p, bpc_pkg::OFF_CONFIG), 8'h0F);
            wr(ad(p, bpc_pkg::OFF_OUTPUT), 8'h35);
            @(negedge clk);
            chk({24'h0, pin_o[8*p +: 8]}, 32'h35);
            chk({24'h0, oe_n[8*p +: 8]}, 32'hF0);
            chk({24'h0, pu[8*p +: 8]}, 32'h30);
            repeat (3) @(posedge clk);
            rd(ad(p, bpc_pkg::OFF_PINS), 8'hB5);
        end
        $display("test pin setup done");
    endtask : t_setup
    task automatic t_wake;
        ext_en[23:16] <= 8'hFC;
        ext_val[23:16] <= 8'h00;
        wr(ad(2, bpc_pkg::OFF_CONFIG), 8'h03);
        wr(ad(2, bpc_pkg::OFF_OUTPUT), 8'h00);
        wr(bpc_pkg::OFF_IRQ_MASK, 8'hFF);
        repeat (4) @(posedge clk);
        wr(bpc_pkg::OFF_IRQ_STATUS, 8'hFF);
        rd(bpc_pkg::OFF_IRQ_STATUS, 8'h00);
        chk({31'h0, irq}, 32'h0);
        ext_val[23:16] <= 8'h10;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({24'h0, wake}, 32'h10);
        chk({30'h0, tb, ta}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        rd(bpc_pkg::OFF_IRQ_STATUS, 8'h10);
        wr(bpc_pkg::OFF_IRQ_MASK, 8'h00);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        wr(bpc_pkg::OFF_IRQ_STATUS, 8'h10);
        rd(bpc_pkg::OFF_IRQ_STATUS, 8'h00);
        $display("test wakeup done");
    endtask : t_wake
    task automatic t_midreset;
        wr(ad(1, bpc_pkg::OFF_CONFIG), 8'hFF);
        wr(ad(1, bpc_pkg::OFF_OUTPUT), 8'h3C);
        chk({24'h0, oe_n[15:8]}, 32'h0);
        chk({24'h0, pin_o[15:8]}, 32'h3C);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({8'h00, pin_o}, 32'h0);
        t_reset;
        $display("test mid-run reset done");
    endtask : t_midreset
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        finish_test;
    end
    initial begin
        {rst, psel, penable, pwrite} = 4'h8;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_val = 24'h0;
        ext_en = 24'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_setup;
        t_wake;
        t_midreset;
        finish_test;
    end
endmodule : tb_top
